// File: logic/led_fault_diagnostic_registers.sv
`timescale 1ns/1ps
`include "fault_diag_cfg.svh"

// Functional notes
// - each detection class runs only while its detect enable bit is one
// - a class drives the fault pin only while its report enable is one
// - report delay field selects two doubling ladders, from 32us (codes 0-7) and 7.8125ms (codes 8-14), 0.5s at the top codes
// - single-short cut bit set: shorted channel current cut to about 4mA
// - string-short cut bit set: shorted channel current cut to about 4mA
// - open cut bit set: open channel current cut to about 4mA
// - eighteen string-short flags, six per register in bits 5:0
// - eighteen open-string flags, six per register in bits 5:0
// - eighteen single-short flags, six per register in bits 5:0
// - summary bit 0 set when any channel is open
// - summary bit 1 set when any channel has a string short
// - summary bit 2 set when any channel has a single LED short
// - summary bit 7 follows thermal current roll-off
// - summary bit 3 follows thermal shutdown
// - summary bit 6 set on interface checksum failure
// - summary bit 4 set on communication time-out
// - summary bit 5 set when the current-set pin is shorted
// - crc error counter counts up once per bad frame
// - crc error counter saturates at ff and never wraps
// - communications reset leaves the counter alone; only reset and writes clear it
// - host may write any eight-bit value into the counter, zero clears
// - detection control resets to open and short detect plus their reports
module led_fault_diagnostic_registers
	import fault_diag_pkg::*;
#(
	parameter int LONG_BASE_CYCLES = `REPORT_LONG_BASE_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire apb_req_type apb_req,
	output apb_rsp_type apb_rsp,
	input wire channel_raw_type channel_raw,
	input wire chip_status_type chip_status,
	input wire logic crc_frame_error,
	output detect_en_type detect_en,
	output logic fault_out_n,
	output logic [17:0] current_cut
);

	// register storage
	logic [5:0] detection_control;
	logic [6:0] fault_response_config;
	logic [7:0] crc_error_count;
	logic [7:0] fault_summary;
	logic [2:0][17:0] fault_flag;
	logic [2:0][`DELAY_WIDTH-1:0] delay_count;
	slave_state_type slave_state;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic fault_pin_n;
	logic [17:0] cut;

	// apb decode
	wire [9:0] word_index = apb_req.paddr[11:2];
	wire aligned = (apb_req.paddr[1:0] == 2'b00);
	wire access = apb_req.psel && apb_req.penable;
	wire commit = access && pready;
	wire write_commit = commit && apb_req.pwrite && apb_req.pstrb[0];
	wire [7:0] wbyte = apb_req.pwdata[7:0];

	wire hit_det = aligned && (word_index == `IDX_DETECTION_CONTROL);
	wire hit_cfg = aligned && (word_index == `IDX_FAULT_RESPONSE_CONFIG);
	wire hit_ss_lo = aligned && (word_index == `IDX_STRING_SHORT_FLAGS_LOW);
	wire hit_ss_mid = aligned && (word_index == `IDX_STRING_SHORT_FLAGS_MID);
	wire hit_ss_hi = aligned && (word_index == `IDX_STRING_SHORT_FLAGS_HIGH);
	wire hit_op_lo = aligned && (word_index == `IDX_OPEN_STRING_FLAGS_LOW);
	wire hit_op_mid = aligned && (word_index == `IDX_OPEN_STRING_FLAGS_MID);
	wire hit_op_hi = aligned && (word_index == `IDX_OPEN_STRING_FLAGS_HIGH);
	wire hit_sl_lo = aligned && (word_index == `IDX_SINGLE_SHORT_FLAGS_LOW);
	wire hit_sl_mid = aligned && (word_index == `IDX_SINGLE_SHORT_FLAGS_MID);
	wire hit_sl_hi = aligned && (word_index == `IDX_SINGLE_SHORT_FLAGS_HIGH);
	wire hit_sum = aligned && (word_index == `IDX_FAULT_SUMMARY);
	wire hit_crc = aligned && (word_index == `IDX_CRC_ERROR_COUNT);
	wire hit_any = hit_det || hit_cfg || hit_ss_lo || hit_ss_mid || hit_ss_hi
		|| hit_op_lo || hit_op_mid || hit_op_hi || hit_sl_lo || hit_sl_mid
		|| hit_sl_hi || hit_sum || hit_crc;

	// named views of the flag vectors
	wire [17:0] open_string_flag_vec = fault_flag[`CLASS_OPEN];
	wire [17:0] string_short_flag_vec = fault_flag[`CLASS_STRING_SHORT];
	wire [17:0] single_short_flag_vec = fault_flag[`CLASS_SINGLE_SHORT];

	// read selection; six flags per register, upper two bits read zero
	wire [7:0] read_byte =
		hit_det ? {2'b00, detection_control} :
		hit_cfg ? {1'b0, fault_response_config} :
		hit_ss_lo ? {2'b00, string_short_flag_vec[5:0]} :
		hit_ss_mid ? {2'b00, string_short_flag_vec[11:6]} :
		hit_ss_hi ? {2'b00, string_short_flag_vec[17:12]} :
		hit_op_lo ? {2'b00, open_string_flag_vec[5:0]} :
		hit_op_mid ? {2'b00, open_string_flag_vec[11:6]} :
		hit_op_hi ? {2'b00, open_string_flag_vec[17:12]} :
		hit_sl_lo ? {2'b00, single_short_flag_vec[5:0]} :
		hit_sl_mid ? {2'b00, single_short_flag_vec[11:6]} :
		hit_sl_hi ? {2'b00, single_short_flag_vec[17:12]} :
		hit_sum ? fault_summary :
		hit_crc ? crc_error_count :
		8'h00;

	// configuration fields
	wire [3:0] report_delay_sel =
		fault_response_config[`CFG_REPORT_DELAY_SEL_MSB:`CFG_REPORT_DELAY_SEL_LSB];
	wire single_short_current_cut = fault_response_config[`CFG_SINGLE_SHORT_CURRENT_CUT];
	wire open_current_cut = fault_response_config[`CFG_OPEN_CURRENT_CUT];
	wire string_short_current_cut = fault_response_config[`CFG_STRING_SHORT_CURRENT_CUT];
	wire [2:0] class_detect_en = {detection_control[`DET_SINGLE_SHORT_DETECT_EN],
		detection_control[`DET_SHORT_DETECT_EN],
		detection_control[`DET_OPEN_DETECT_EN]};
	wire [2:0] class_report_en = {detection_control[`DET_SINGLE_SHORT_PIN_REPORT_EN],
		detection_control[`DET_SHORT_PIN_REPORT_EN],
		detection_control[`DET_OPEN_PIN_REPORT_EN]};
	wire [2:0][17:0] class_raw = {channel_raw.single_short, channel_raw.string_short,
		channel_raw.open_string};

	// report delay: two doubling ladders, top code held at the longest delay
	wire [3:0] top_sel = (report_delay_sel > 4'(`REPORT_TOP_CODE))
		? 4'(`REPORT_TOP_CODE) : report_delay_sel;
	wire [2:0] ladder_shift = top_sel[2:0];
	wire [`DELAY_WIDTH-1:0] short_base = `DELAY_WIDTH'(`REPORT_SHORT_BASE_CYCLES);
	wire [`DELAY_WIDTH-1:0] long_base = `DELAY_WIDTH'(LONG_BASE_CYCLES);
	wire [`DELAY_WIDTH-1:0] delay_cycles = top_sel[3]
		? (long_base << ladder_shift) : (short_base << ladder_shift);

	// crc counter next value; a bad frame in the cycle of a write still counts
	wire [7:0] crc_base = (write_commit && hit_crc) ? wbyte : crc_error_count;
	wire [7:0] next_crc_error_count = (crc_frame_error && (crc_base != `CRC_COUNT_MAX))
		? 8'(crc_base + 8'h01) : crc_base;

	// per-class detection timers and flags
	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1)
		begin : g_class
			// a disabled class sees nothing, so its flags and timer stay clear
			wire [17:0] gated = class_raw[k] & {18{class_detect_en[k]}};
			wire active = |gated;
			wire expired = (delay_count[k] >= delay_cycles);

			// the timer only needs to run while some channel of the class is faulty;
			// sharing one timer per class costs per-channel deglitch independence
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					delay_count[k] <= '0;
				else if (!active)
					delay_count[k] <= '0;
				else if (!expired)
					delay_count[k] <= delay_count[k] + `DELAY_WIDTH'(1);
			end

			// flags follow the detector once the delay has run out
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					fault_flag[k] <= '0;
				else if (active && expired)
					fault_flag[k] <= gated;
				else
					fault_flag[k] <= '0;
			end
		end
	endgenerate

	// pin report and current reduction from the qualified flags
	wire [2:0] class_any = {|single_short_flag_vec, |string_short_flag_vec,
		|open_string_flag_vec};
	wire next_fault_pin_n = ~|(class_any & class_report_en);
	wire [17:0] next_cut = (open_string_flag_vec & {18{open_current_cut}})
		| (string_short_flag_vec & {18{string_short_current_cut}})
		| (single_short_flag_vec & {18{single_short_current_cut}});

	// summary register, rebuilt every cycle so it is live status
	wire [7:0] next_fault_summary = {chip_status.thermal_rolloff,
		chip_status.checksum_fail,
		chip_status.current_set_pin_short,
		chip_status.comm_timeout,
		chip_status.thermal_shutdown,
		class_any[`CLASS_SINGLE_SHORT],
		class_any[`CLASS_STRING_SHORT],
		class_any[`CLASS_OPEN]};

	// writable registers; flag and summary registers have no write path
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			detection_control <= `RST_DETECTION_CONTROL;
			fault_response_config <= `RST_FAULT_RESPONSE_CONFIG;
		end
		else if (write_commit)
		begin
			if (hit_det)
				detection_control <= wbyte[5:0];
			if (hit_cfg)
				fault_response_config <= wbyte[6:0];
		end
	end

	// counter has no clear but reset and writes; comms reset is not wired here
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			crc_error_count <= `RST_CRC_ERROR_COUNT;
		else
			crc_error_count <= next_crc_error_count;
	end

	// status and drive outputs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fault_summary <= 8'h00;
			fault_pin_n <= 1'b1;
			cut <= '0;
		end
		else
		begin
			fault_summary <= next_fault_summary;
			fault_pin_n <= next_fault_pin_n;
			cut <= next_cut;
		end
	end

	// one wait state: answer in the second access cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slave_state <= SLAVE_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			unique case (slave_state)
				SLAVE_IDLE:
				begin
					if (access)
					begin
						slave_state <= SLAVE_READY;
						pready <= 1'b1;
						pslverr <= !hit_any;
						prdata <= apb_req.pwrite ? 32'h0000_0000 : {24'h00_0000, read_byte};
					end
				end
				SLAVE_READY:
				begin
					slave_state <= SLAVE_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
					prdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	// outputs straight from flops
	assign apb_rsp.prdata = prdata;
	assign apb_rsp.pready = pready;
	assign apb_rsp.pslverr = pslverr;
	assign detect_en.open_detect_en = detection_control[`DET_OPEN_DETECT_EN];
	assign detect_en.short_detect_en = detection_control[`DET_SHORT_DETECT_EN];
	assign detect_en.single_short_detect_en = detection_control[`DET_SINGLE_SHORT_DETECT_EN];
	assign fault_out_n = fault_pin_n;
	assign current_cut = cut;

endmodule

// File: logic/fault_diag_cfg.svh
`ifndef FAULT_DIAG_CFG_SVH
`define FAULT_DIAG_CFG_SVH

// register word indices; byte address is four times the index
`define IDX_DETECTION_CONTROL 10'h04c
`define IDX_FAULT_RESPONSE_CONFIG 10'h04d
`define IDX_STRING_SHORT_FLAGS_LOW 10'h04e
`define IDX_STRING_SHORT_FLAGS_MID 10'h04f
`define IDX_STRING_SHORT_FLAGS_HIGH 10'h050
`define IDX_OPEN_STRING_FLAGS_LOW 10'h051
`define IDX_OPEN_STRING_FLAGS_MID 10'h052
`define IDX_OPEN_STRING_FLAGS_HIGH 10'h053
`define IDX_SINGLE_SHORT_FLAGS_LOW 10'h054
`define IDX_SINGLE_SHORT_FLAGS_MID 10'h055
`define IDX_SINGLE_SHORT_FLAGS_HIGH 10'h056
`define IDX_FAULT_SUMMARY 10'h057
`define IDX_CRC_ERROR_COUNT 10'h059

// reset values
`define RST_DETECTION_CONTROL 6'h0f
`define RST_FAULT_RESPONSE_CONFIG 7'h63
`define RST_CRC_ERROR_COUNT 8'h00

// detection_control fields: class k detect at bit 2k, pin report at 2k+1
`define DET_OPEN_DETECT_EN 0
`define DET_OPEN_PIN_REPORT_EN 1
`define DET_SHORT_DETECT_EN 2
`define DET_SHORT_PIN_REPORT_EN 3
`define DET_SINGLE_SHORT_DETECT_EN 4
`define DET_SINGLE_SHORT_PIN_REPORT_EN 5

// fault_response_config fields
`define CFG_REPORT_DELAY_SEL_LSB 0
`define CFG_REPORT_DELAY_SEL_MSB 3
`define CFG_SINGLE_SHORT_CURRENT_CUT 4
`define CFG_OPEN_CURRENT_CUT 5
`define CFG_STRING_SHORT_CURRENT_CUT 6

// fault class indices, equal to the summary bit of each class
`define CLASS_OPEN 0
`define CLASS_STRING_SHORT 1
`define CLASS_SINGLE_SHORT 2

// fault_summary fields
`define SUM_THERMAL_SHUTDOWN 3
`define SUM_COMM_TIMEOUT 4
`define SUM_CURRENT_SET_PIN_SHORT 5
`define SUM_CHECKSUM_FAIL 6
`define SUM_THERMAL_ROLLOFF 7

// channels and packing
`define CHANNELS 18
`define FLAGS_PER_REG 6

// timing
`define CLK_PERIOD_NS 100
`define REPORT_SHORT_BASE_NS 32000
`define REPORT_LONG_BASE_NS 7812500
`define REPORT_SHORT_BASE_CYCLES ((`REPORT_SHORT_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REPORT_LONG_BASE_CYCLES ((`REPORT_LONG_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REPORT_LONG_CODE 8
`define REPORT_TOP_CODE 14
`define DELAY_WIDTH 23

`define CRC_COUNT_MAX 8'hff

`endif

// File: logic/fault_diag_pkg.sv
package fault_diag_pkg;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_type;

	// apb answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_type;

	// raw per-channel detector outputs, one vector per class
	typedef struct packed {
		logic [17:0] single_short;
		logic [17:0] string_short;
		logic [17:0] open_string;
	} channel_raw_type;

	// chip-level fault levels from the analog and interface blocks
	typedef struct packed {
		logic thermal_rolloff;
		logic checksum_fail;
		logic current_set_pin_short;
		logic comm_timeout;
		logic thermal_shutdown;
	} chip_status_type;

	// detect enables driven out to the analog detectors
	typedef struct packed {
		logic single_short_detect_en;
		logic short_detect_en;
		logic open_detect_en;
	} detect_en_type;

	// slave answer state
	typedef enum logic [1:0] {
		SLAVE_IDLE = 2'b01,
		SLAVE_READY = 2'b10
	} slave_state_type;

endpackage

// File: tb/fault_diag_monitor.sv
`timescale 1ns/1ps
// watches only the register block's ports
module fault_diag_monitor
	import fault_diag_pkg::*;
#(
	parameter int LONG_BASE_CYCLES = 78125
)
(
	input logic clk,
	input logic rst_n,
	input apb_req_type apb_req,
	input apb_rsp_type apb_rsp,
	input channel_raw_type channel_raw,
	input chip_status_type chip_status,
	input logic crc_frame_error,
	input detect_en_type detect_en,
	input logic fault_out_n,
	input logic [17:0] current_cut
);
	// shortest report delay any code can give
	localparam int MIN_DLY = (LONG_BASE_CYCLES < 320) ? LONG_BASE_CYCLES : 320;
	int run_cnt;
	wire any_raw = |channel_raw;

	// cycles of unbroken detector activity, capped so it never wraps
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			run_cnt <= 0;
		else
			run_cnt <= any_raw ? ((run_cnt < 100000) ? run_cnt + 1 : run_cnt) : 0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ready_one_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
		|=> apb_rsp.pready) else $error("pready not one cycle after access");
	a_ready_one_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	a_err_zero_data: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 0)
		else $error("error answer with data");
	a_reset_detect_en: assert property ($rose(rst_n) |-> detect_en == 3'h3 && fault_out_n)
		else $error("detect enables wrong after reset");
	a_cut_needs_raw: assert property (|current_cut |-> $past(any_raw, 2) || $past(any_raw, 3))
		else $error("current cut without fault");
	a_pin_needs_raw: assert property (!fault_out_n |-> $past(any_raw, 2) || $past(any_raw, 3))
		else $error("fault pin without fault");
	a_pin_min_delay: assert property ($fell(fault_out_n) |-> run_cnt >= MIN_DLY)
		else $error("fault reported before delay");
	a_idle_no_fault: assert property (!any_raw [*4] |=> fault_out_n && current_cut == '0)
		else $error("fault outputs stay without cause");

	cover property (apb_rsp.pslverr);
	cover property ($fell(fault_out_n));
	cover property (|current_cut);
endmodule

bind led_fault_diagnostic_registers fault_diag_monitor #(.LONG_BASE_CYCLES(LONG_BASE_CYCLES))
	i_fault_diag_monitor (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.channel_raw(channel_raw), .chip_status(chip_status), .crc_frame_error(crc_frame_error),
	.detect_en(detect_en), .fault_out_n(fault_out_n), .current_cut(current_cut));

// File: tb/apb_host.sv
`timescale 1ns/1ps
// host side: an apb master that waits for pready under a bound
module apb_host
	import fault_diag_pkg::*;
(
	input logic clk,
	output apb_req_type req,
	input apb_rsp_type rsp
);
	initial req = '0;

	// the answer is taken at the rising edge that samples pready high, then released
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err, output logic to);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd, pstrb: 4'hf};
		@(posedge clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 50);
		rd = rsp.prdata;
		err = rsp.pslverr;
		to = (rsp.pready !== 1'b1);
		req <= '0;
	endtask
endmodule

// File: tb/led_fault_diagnostic_registers_test.sv
`timescale 1ns/1ps
`include "fault_diag_cfg.svh"
module led_fault_diagnostic_registers_test
	import fault_diag_pkg::*;
;
	logic clk = 0;
	logic rst_n = 0;
	logic crc_frame_error = 0;
	channel_raw_type channel_raw = '0;
	chip_status_type chip_status = '0;
	apb_req_type apb_req;
	apb_rsp_type apb_rsp;
	detect_en_type detect_en;
	logic fault_out_n;
	logic [17:0] current_cut;
	int error_cnt = 0;
	int compares = 0;
	logic [9:0] b;
	logic [17:0] pat;
	logic [17:0] f;
	logic [31:0] r;
	logic e;
	logic [7:0] dctl [3] = '{8'h3f, 8'h15, 8'h00};

	always #50 clk = ~clk;

	apb_host i_apb_host (.clk(clk), .req(apb_req), .rsp(apb_rsp));
	led_fault_diagnostic_registers i_led_fault_diagnostic_registers (.clk(clk), .rst_n(rst_n),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .channel_raw(channel_raw),
		.chip_status(chip_status), .crc_frame_error(crc_frame_error), .detect_en(detect_en),
		.fault_out_n(fault_out_n), .current_cut(current_cut));

	task automatic results();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// a hung transfer ends the run at once
	task automatic acc(input logic w, input logic [9:0] idx, input logic [31:0] wd);
		logic to;
		i_apb_host.xfer(w, {idx, 2'b00}, wd, r, e, to);
		if (to)
		begin
			error_cnt++;
			$display("[FAIL] %0t no pready", $time);
			results();
		end
	endtask

	task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
		acc(1'b0, idx, 32'h0000_0000);
		chk(r, exp);
	endtask

	task automatic pulse();
		@(posedge clk) crc_frame_error <= 1'b1;
		@(posedge clk) crc_frame_error <= 1'b0;
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		// reset values, read-only places and the unmapped hole
		for (int i = `IDX_DETECTION_CONTROL; i <= `IDX_CRC_ERROR_COUNT; i++)
			if (i != 10'h058)
				rdc(10'(i), i == 10'h04c ? 8'h0f : i == 10'h04d ? 8'h63 : 8'h00);
		acc(1'b1, `IDX_FAULT_SUMMARY, 32'h0000_00ff);
		acc(1'b1, `IDX_OPEN_STRING_FLAGS_LOW, 32'h0000_003f);
		rdc(`IDX_FAULT_SUMMARY, 8'h00);
		rdc(`IDX_OPEN_STRING_FLAGS_LOW, 8'h00);
		acc(1'b1, 10'h058, 32'h0000_0001);
		chk(32'(e), 32'h0000_0001);
		$display("test registers done");
		// each chip-level status lands on its own summary bit
		for (int k = 0; k < 5; k++)
		begin
			@(posedge clk) chip_status <= chip_status_type'(5'(1 << k));
			repeat (2) @(posedge clk);
			rdc(`IDX_FAULT_SUMMARY, 32'h0000_0008 << k);
		end
		@(posedge clk) chip_status <= '0;
		$display("test status done");
		// every class under full, detect-only and disabled settings
		for (int c = 0; c < 3; c++)
			for (int m = 0; m < 3; m++)
			begin
				pat = 18'h2_0001 | (18'h0_0040 << (c + m));
				acc(1'b1, `IDX_DETECTION_CONTROL, 32'(dctl[m]));
				acc(1'b1, `IDX_FAULT_RESPONSE_CONFIG, m == 0 ? 32'h0000_0070 : 32'h0000_0000);
				@(posedge clk) channel_raw <= channel_raw_type'(54'(pat) << (18 * c));
				repeat (300) @(posedge clk);
				@(negedge clk);
				chk(32'(detect_en), {29'h0, dctl[m][4], dctl[m][2], dctl[m][0]});
				chk(32'(fault_out_n), 32'h0000_0001);
				repeat (30) @(negedge clk);
				chk(32'(fault_out_n), 32'(m != 0));
				chk(32'(current_cut), m == 0 ? 32'(pat) : 32'h0000_0000);
				b = c == 0 ? `IDX_OPEN_STRING_FLAGS_LOW : c == 1 ?
					`IDX_STRING_SHORT_FLAGS_LOW : `IDX_SINGLE_SHORT_FLAGS_LOW;
				f = m == 2 ? 18'h0_0000 : pat;
				rdc(b, 32'(f[5:0]));
				rdc(b + 10'h001, 32'(f[11:6]));
				rdc(b + 10'h002, 32'(f[17:12]));
				rdc(`IDX_FAULT_SUMMARY, m == 2 ? 32'h0000_0000 : 32'h0000_0001 << c);
				@(posedge clk) channel_raw <= '0;
				repeat (5) @(negedge clk);
				chk(32'(current_cut), 32'h0000_0000);
			end
		$display("test faults done");
		// counter saturates, clears by write, counts again
		acc(1'b1, `IDX_CRC_ERROR_COUNT, 32'h0000_00fd);
		repeat (3) pulse();
		rdc(`IDX_CRC_ERROR_COUNT, 8'hff);
		acc(1'b1, `IDX_CRC_ERROR_COUNT, 32'h0000_0000);
		rdc(`IDX_CRC_ERROR_COUNT, 8'h00);
		repeat (2) pulse();
		rdc(`IDX_CRC_ERROR_COUNT, 8'h02);
		acc(1'b1, `IDX_CRC_ERROR_COUNT, 32'h0000_005a);
		rdc(`IDX_CRC_ERROR_COUNT, 8'h5a);
		$display("test counter done");
		results();
	end
endmodule
